// File: src/msb_top.sv
// Our own choice: the plain strobed port.
`timescale 1ns/10ps
// ==========================================================================
module msb_top #(
  parameter int ADDR_W = msb_pkg::ADDR_W
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  // Register port
  input wire logic [ADDR_W-1:0] REG_ADDR,
  input wire logic [msb_pkg::DATA_W-1:0] REG_WDATA,
  input wire logic [msb_pkg::BYTES_W-1:0] REG_BYTE_EN,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [msb_pkg::DATA_W-1:0] REG_RDATA,
  // Request lines, one-cycle pulses
  output logic [msb_pkg::NUM_VME_LINE:1] VME_IRQ_PULSE,
  output logic [msb_pkg::NUM_LOC_LINE-1:0] LOCAL_IRQ_PULSE
);
  import msb_pkg::*;

  // ========================================================================
  // Elaboration checks
  // The highest offset needs ten address bits; ports over twelve bits would alias
  if (ADDR_W < 10 || ADDR_W > 12) begin : g_bad_addr
    $error("msb_top: ADDR_W must lie between 10 and 12");
  end

  // ========================================================================
  // Helper functions
  // Address to register select
  function automatic msb_sel_t reg_sel(input logic [11:0] a);
    case (a)
      OFS_VME_ROUTE: return SEL_VROUTE;
      OFS_SEM_HIGH: return SEL_SEMHI;
      OFS_SEM_LOW: return SEL_SEMLO;
      OFS_MAILBOX_WORD_0: return SEL_MB0;
      OFS_MAILBOX_WORD_1: return SEL_MB1;
      OFS_MAILBOX_WORD_2: return SEL_MB2;
      OFS_MAILBOX_WORD_3: return SEL_MB3;
      OFS_PCI_ROUTE: return SEL_PROUTE;
      OFS_LOC_EN: return SEL_LOCEN;
      default: return SEL_NONE;
    endcase
  endfunction

  // Byte-lane merge of old and new word
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_w,
                                              input logic [DATA_W-1:0] new_w,
                                              input logic [BYTES_W-1:0] be);
    logic [DATA_W-1:0] res;
    res = old_w;
    for (int b = 0; b < BYTES_W; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // ========================================================================
  // Declarations
  msb_state_t st_q;
  msb_state_t st_d;
  msb_sel_t sel;
  logic [3:0] mb_hit;
  logic [NUM_SLOT-1:0] sem_wr;
  logic [NUM_SLOT-1:0][7:0] sem_nxt;
  logic [NUM_VME_LINE:1] vme_hit;
  logic [NUM_LOC_LINE-1:0] loc_hit;

  // Decode once, shared by write and read paths
  assign sel = reg_sel(12'(REG_ADDR));

  // Mailbox write events, regardless of byte lanes
  always_comb begin
    for (int i = 0; i < NUM_MBOX; i++) begin
      mb_hit[i] = REG_WR && (sel == msb_sel_t'(SEL_MB0 + 4'(i)));
    end
  end

  // ========================================================================
  // Semaphore slots
  for (genvar k = 0; k < NUM_SLOT; k++) begin : g_slot
    // Slots 0-3 in the low register, 4-7 in the high, lowest byte first
    assign sem_wr[k] = REG_WR && REG_BYTE_EN[k % SLOTS_PER_REG]
                       && (sel == ((k < SLOTS_PER_REG) ? SEL_SEMLO : SEL_SEMHI));
    msb_sem_slot u_slot (
      .cur_byte(st_q.sem[k]),
      .wr_en(sem_wr[k]),
      .wr_byte(REG_WDATA[(k % SLOTS_PER_REG)*8 +: 8]),
      .nxt_byte(sem_nxt[k])
    );
  end

  // ========================================================================
  // Event routing
  msb_irq_route u_route (
    .mb_hit(mb_hit),
    .vme_route(st_q.vroute),
    .pci_route(st_q.proute),
    .loc_en(st_q.loc_en),
    .vme_line(vme_hit),
    .loc_line(loc_hit)
  );

  // ========================================================================
  // Next state
  // Read data only lives one cycle, so it returns to zero otherwise
  always_comb begin
    st_d = st_q;
    st_d.rdata = RST_WORD;
    st_d.vme_irq = vme_hit;
    st_d.loc_irq = loc_hit;
    st_d.sem = sem_nxt;
    if (REG_WR) begin
      case (sel)
        // Upper half is all reserved, so it is cut off on purpose
        SEL_VROUTE: st_d.vroute = 16'(merge(32'(st_q.vroute), REG_WDATA, REG_BYTE_EN)
                                      & 32'(ROUTE_MASK));
        SEL_PROUTE: st_d.proute = 16'(merge(32'(st_q.proute), REG_WDATA, REG_BYTE_EN)
                                      & 32'(ROUTE_MASK));
        SEL_LOCEN: begin
          if (REG_BYTE_EN[0]) begin
            st_d.loc_en = REG_WDATA[NUM_MBOX-1:0];
          end
        end
        SEL_MB0, SEL_MB1, SEL_MB2, SEL_MB3: begin
          st_d.mbox[sel[1:0]] = merge(st_q.mbox[sel[1:0]], REG_WDATA, REG_BYTE_EN);
        end
        default: begin
        end
      endcase
    end
    // Unmapped addresses read as zero
    if (REG_RD) begin
      case (sel)
        SEL_VROUTE: st_d.rdata = 32'(st_q.vroute);
        SEL_PROUTE: st_d.rdata = 32'(st_q.proute);
        SEL_LOCEN: st_d.rdata = 32'(st_q.loc_en);
        SEL_SEMLO: st_d.rdata = st_q.sem[3:0];
        SEL_SEMHI: st_d.rdata = st_q.sem[7:4];
        SEL_MB0, SEL_MB1, SEL_MB2, SEL_MB3: st_d.rdata = st_q.mbox[sel[1:0]];
        default: st_d.rdata = RST_WORD;
      endcase
    end
  end

  // ========================================================================
  // State register
  // Everything clears at reset, so every route masks until programmed
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state register
  assign REG_RDATA = st_q.rdata;
  assign VME_IRQ_PULSE = st_q.vme_irq;
  assign LOCAL_IRQ_PULSE = st_q.loc_irq;

  // ========================================================================
  // Assertions
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);

  // Routed mailbox 0 write pulses its chosen VME line
  property p_vme_hit;
    (mb_hit[0] && st_q.vroute[2:0] != ROUTE_OFF)
      |=> VME_IRQ_PULSE[$past(st_q.vroute[2:0])];
  endproperty
  a_vme_hit: assert property (p_vme_hit) else $error("routed mailbox write missed VME line");

  // Zero route keeps VME lines quiet
  property p_vme_mask;
    (mb_hit[1] && st_q.vroute[6:4] == ROUTE_OFF) |=> VME_IRQ_PULSE == '0;
  endproperty
  a_vme_mask: assert property (p_vme_mask) else $error("masked mailbox raised a VME line");

  // Route register written then read back
  property p_route_rw;
    (REG_WR && sel == SEL_VROUTE && REG_BYTE_EN == 4'hF) ##1 (REG_RD && sel == SEL_VROUTE)
      |=> REG_RDATA == ($past(REG_WDATA, 2) & 32'(ROUTE_MASK));
  endproperty
  a_route_rw: assert property (p_route_rw) else $error("VME route readback wrong");

  // Full mailbox write stores the word
  property p_mbox_store;
    (mb_hit[2] && REG_BYTE_EN == 4'hF) |=> st_q.mbox[2] == $past(REG_WDATA);
  endproperty
  a_mbox_store: assert property (p_mbox_store) else $error("mailbox word not stored");

  // Enabled local event lands on its mapped line
  property p_loc_hit;
    (mb_hit[3] && st_q.loc_en[3]) |=> LOCAL_IRQ_PULSE[$past(st_q.proute[14:12])];
  endproperty
  a_loc_hit: assert property (p_loc_hit) else $error("enabled local event missing");

  // Local pulses only follow an enabled mailbox write
  property p_loc_cause;
    LOCAL_IRQ_PULSE != '0 |-> $past(|(mb_hit & st_q.loc_en));
  endproperty
  a_loc_cause: assert property (p_loc_cause) else $error("local pulse without cause");

  // Low semaphore read shows slots 0-3
  property p_sem_low_rd;
    (REG_RD && sel == SEL_SEMLO) |=> REG_RDATA == $past(32'(st_q.sem[3:0]));
  endproperty
  a_sem_low_rd: assert property (p_sem_low_rd) else $error("low semaphore read wrong");

  // High semaphore read shows slots 4-7
  property p_sem_high_rd;
    (REG_RD && sel == SEL_SEMHI) |=> REG_RDATA == $past(32'(st_q.sem[7:4]));
  endproperty
  a_sem_high_rd: assert property (p_sem_high_rd) else $error("high semaphore read wrong");

  // Free slot takes the written tag
  property p_tag_free;
    (sem_wr[0] && !st_q.sem[0][LOCK_BIT]) |=> st_q.sem[0][TAG_W-1:0] == $past(REG_WDATA[TAG_W-1:0]);
  endproperty
  a_tag_free: assert property (p_tag_free) else $error("free slot tag not written");

  // Locked slot holds its tag
  property p_tag_locked;
    st_q.sem[5][LOCK_BIT] |=> $stable(st_q.sem[5][TAG_W-1:0]);
  endproperty
  a_tag_locked: assert property (p_tag_locked) else $error("locked slot tag changed");

  // Claim on a free slot then readback confirms ownership
  property p_claim;
    (sem_wr[4] && !st_q.sem[4][LOCK_BIT] && REG_WDATA[LOCK_BIT]) ##1 (REG_RD && sel == SEL_SEMHI)
      |=> REG_RDATA[7:0] == $past(REG_WDATA[7:0], 2);
  endproperty
  a_claim: assert property (p_claim) else $error("claim readback mismatch");

  // Read data stands for one cycle only
  property p_rdata_once;
    !REG_RD |=> REG_RDATA == RST_WORD;
  endproperty
  a_rdata_once: assert property (p_rdata_once) else $error("read data outlived its cycle");

  // Any VME pulse follows a mailbox write
  property p_vme_cause;
    VME_IRQ_PULSE != '0 |-> $past(|mb_hit);
  endproperty
  a_vme_cause: assert property (p_vme_cause) else $error("VME pulse without mailbox write");

  // Routed mailbox 3 write pulses its chosen VME line
  property p_vme_hit3;
    (mb_hit[3] && st_q.vroute[14:12] != ROUTE_OFF)
      |=> VME_IRQ_PULSE[$past(st_q.vroute[14:12])];
  endproperty
  a_vme_hit3: assert property (p_vme_hit3) else $error("mailbox 3 write missed VME line");

  // Zero route on mailbox 3 keeps VME lines quiet
  property p_vme_mask3;
    (mb_hit[3] && st_q.vroute[14:12] == ROUTE_OFF) |=> VME_IRQ_PULSE == '0;
  endproperty
  a_vme_mask3: assert property (p_vme_mask3) else $error("masked mailbox 3 raised a VME line");

  // Disabled local path stays quiet
  property p_loc_off;
    (mb_hit[0] && !st_q.loc_en[0]) |=> LOCAL_IRQ_PULSE == '0;
  endproperty
  a_loc_off: assert property (p_loc_off) else $error("disabled local event pulsed");

  // Mailboxes change only when written
  property p_mbox_hold;
    mb_hit == '0 |=> $stable(st_q.mbox);
  endproperty
  a_mbox_hold: assert property (p_mbox_hold) else $error("mailbox changed without write");

  // Slots change only when written
  property p_sem_hold;
    !REG_WR |=> $stable(st_q.sem);
  endproperty
  a_sem_hold: assert property (p_sem_hold) else $error("slot changed without write");

  // Lock bit follows every write, so any agent can release
  property p_lock_wr;
    sem_wr[6] |=> st_q.sem[6][LOCK_BIT] == $past(REG_WDATA[16+LOCK_BIT]);
  endproperty
  a_lock_wr: assert property (p_lock_wr) else $error("lock bit ignored write");

  // Locked slot in the low register holds its tag
  property p_tag_locked2;
    st_q.sem[2][LOCK_BIT] |=> $stable(st_q.sem[2][TAG_W-1:0]);
  endproperty
  a_tag_locked2: assert property (p_tag_locked2) else $error("locked low slot tag changed");

  // Main scenarios
  c_vme_pulse: cover property (mb_hit[0] ##1 VME_IRQ_PULSE != '0);
  c_claim: cover property (sem_wr[0] && REG_WDATA[LOCK_BIT] ##1 st_q.sem[0][LOCK_BIT]);
  c_locked_write: cover property (sem_wr[1] && st_q.sem[1][LOCK_BIT]);
  c_local_pulse: cover property (LOCAL_IRQ_PULSE != '0);

endmodule // msb_top

// File: src/msb_pkg.sv
// ==========================================================================
// Shared constants and types of the mailbox and semaphore bank
package msb_pkg;

  // ========================================================================
  // Widths and counts
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int BYTES_W = 4;
  localparam int NUM_MBOX = 4;
  localparam int NUM_SLOT = 8;
  localparam int SLOTS_PER_REG = 4;
  localparam int NUM_VME_LINE = 7;
  localparam int NUM_LOC_LINE = 8;

  // ========================================================================
  // Register offsets (byte addresses)
  localparam logic [11:0] OFS_VME_ROUTE = 12'h344;
  localparam logic [11:0] OFS_SEM_HIGH = 12'h350;
  localparam logic [11:0] OFS_SEM_LOW = 12'h358;
  localparam logic [11:0] OFS_MAILBOX_WORD_0 = 12'h360;
  localparam logic [11:0] OFS_MAILBOX_WORD_1 = 12'h364;
  localparam logic [11:0] OFS_MAILBOX_WORD_2 = 12'h368;
  localparam logic [11:0] OFS_MAILBOX_WORD_3 = 12'h36C;
  localparam logic [11:0] OFS_PCI_ROUTE = 12'h370;
  localparam logic [11:0] OFS_LOC_EN = 12'h374;

  // ========================================================================
  // Field layout and reset values
  localparam int ROUTE_W = 3;
  localparam int ROUTE_STRIDE = 4;
  localparam int LOCK_BIT = 7;
  localparam int TAG_W = 7;
  localparam logic [2:0] ROUTE_OFF = 3'h0;
  localparam logic [15:0] ROUTE_MASK = 16'h7777;
  localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;

  // ========================================================================
  // Decoded register select
  typedef enum logic [3:0] {
    SEL_NONE = 4'h0,
    SEL_VROUTE = 4'h1,
    SEL_SEMHI = 4'h2,
    SEL_SEMLO = 4'h3,
    SEL_MB0 = 4'h4,
    SEL_MB1 = 4'h5,
    SEL_MB2 = 4'h6,
    SEL_MB3 = 4'h7,
    SEL_PROUTE = 4'h8,
    SEL_LOCEN = 4'h9
  } msb_sel_t;

  // ========================================================================
  // Whole state of the bank
  typedef struct packed {
    logic [NUM_MBOX-1:0][DATA_W-1:0] mbox;
    logic [NUM_SLOT-1:0][7:0] sem;
    logic [15:0] vroute;
    logic [15:0] proute;
    logic [NUM_MBOX-1:0] loc_en;
    logic [DATA_W-1:0] rdata;
    logic [NUM_VME_LINE:1] vme_irq;
    logic [NUM_LOC_LINE-1:0] loc_irq;
  } msb_state_t;

endpackage

// File: src/msb_sem_slot.sv
`timescale 1ns/10ps
// ==========================================================================
// One semaphore slot: lock bit over a 7-bit owner tag
module msb_sem_slot (
  // Current slot value and bus byte
  input wire logic [7:0] cur_byte,
  input wire logic wr_en,
  input wire logic [7:0] wr_byte,
  // Value for the next cycle
  output logic [7:0] nxt_byte
);
  import msb_pkg::*;

  // Lock bit always writable so any owner can release; tag only while free
  always_comb begin
    nxt_byte = cur_byte;
    if (wr_en) begin
      nxt_byte[LOCK_BIT] = wr_byte[LOCK_BIT];
      if (!cur_byte[LOCK_BIT]) begin
        nxt_byte[TAG_W-1:0] = wr_byte[TAG_W-1:0];
      end
    end
  end

endmodule // msb_sem_slot

// File: src/msb_irq_route.sv
`timescale 1ns/10ps
// ==========================================================================
// Steers mailbox write events onto request lines
module msb_irq_route (
  // Mailbox write events
  input wire logic [3:0] mb_hit,
  // Route words and local enables
  input wire logic [15:0] vme_route,
  input wire logic [15:0] pci_route,
  input wire logic [3:0] loc_en,
  // Request lines
  output logic [7:1] vme_line,
  output logic [7:0] loc_line
);
  import msb_pkg::*;

  // Several mailboxes may share one line; their events merge
  always_comb begin
    vme_line = '0;
    loc_line = '0;
    for (int i = 0; i < NUM_MBOX; i++) begin
      if (mb_hit[i] && vme_route[i*ROUTE_STRIDE +: ROUTE_W] != ROUTE_OFF) begin
        vme_line[vme_route[i*ROUTE_STRIDE +: ROUTE_W]] = 1'b1;
      end
      if (mb_hit[i] && loc_en[i]) begin
        loc_line[pci_route[i*ROUTE_STRIDE +: ROUTE_W]] = 1'b1;
      end
    end
  end

endmodule // msb_irq_route

// File: sim/msb_top_tb.sv
`timescale 1ns/10ps
// ==========================================================================
// Self-checking bench for the mailbox and semaphore bank
module msb_top_tb;
  import msb_pkg::*;

  // ========================================================================
  // Stimulus and observed signals
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic [BYTES_W-1:0] reg_byte_en = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic [NUM_VME_LINE:1] vme_irq;
  logic [NUM_LOC_LINE-1:0] loc_irq;
  int n_mismatch = 0;
  int checked = 0;

  // 10 MHz system clock
  always #50 clk_sys = ~clk_sys;

  msb_top #(.ADDR_W(ADDR_W)) DUT (
    .CLK_SYS(clk_sys),
    .ARST_N(arst_n),
    .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata),
    .REG_BYTE_EN(reg_byte_en),
    .REG_WR(reg_wr),
    .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata),
    .VME_IRQ_PULSE(vme_irq),
    .LOCAL_IRQ_PULSE(loc_irq)
  );

  // ========================================================================
  // Compare and bus tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Returns just after the taking edge, so pulses are seen in their cycle
  task automatic bus_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_byte_en <= be;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(what, exp, reg_rdata);
  endtask

  // Write then read back the same register with no idle cycle between
  task automatic wr_rd_chk(input string what, input logic [11:0] a, input logic [31:0] d,
                           input logic [3:0] be, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_byte_en <= be;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(what, exp, reg_rdata);
  endtask

  // One-cycle pulses: check the cycle, then the return to zero
  task automatic irq_chk(input logic [7:1] ev, input logic [7:0] el);
    chk("vme pulse", {25'h0, ev}, {25'h0, vme_irq});
    chk("local pulse", {24'h0, el}, {24'h0, loc_irq});
    @(posedge clk_sys);
    #1;
    chk("vme pulse end", 32'h0, {25'h0, vme_irq});
    chk("local pulse end", 32'h0, {24'h0, loc_irq});
  endtask

  function automatic logic [11:0] mb_ofs(input int i);
    return OFS_MAILBOX_WORD_0 + 12'(4 * i);
  endfunction

  // Single-lane access only, so each write reaches exactly one slot
  task automatic sem_wr(input int s, input logic [7:0] b);
    bus_wr((s < 4) ? OFS_SEM_LOW : OFS_SEM_HIGH, 32'(b) << (8 * (s % 4)), 4'(1) << (s % 4));
  endtask

  // Lower slots of the same register already hold the final free tag 2A
  function automatic logic [31:0] sem_exp(input int s, input logic [7:0] b);
    logic [31:0] done_lanes;
    done_lanes = 32'h2A2A_2A2A & ((32'h1 << (8 * (s % 4))) - 32'h1);
    return done_lanes | (32'(b) << (8 * (s % 4)));
  endfunction

  task automatic sem_chk(input int s, input logic [7:0] b);
    rd_chk("semaphore slot", (s < 4) ? OFS_SEM_LOW : OFS_SEM_HIGH, sem_exp(s, b));
  endtask

  // Claim and confirm back to back, as an agent would
  task automatic sem_claim(input int s, input logic [7:0] b);
    wr_rd_chk("semaphore claim", (s < 4) ? OFS_SEM_LOW : OFS_SEM_HIGH, 32'(b) << (8 * (s % 4)),
              4'(1) << (s % 4), sem_exp(s, b));
  endtask

  // ========================================================================
  // Scenarios
  task automatic t_reset();
    rd_chk("vme route", OFS_VME_ROUTE, 32'h0);
    rd_chk("sem high", OFS_SEM_HIGH, 32'h0);
    rd_chk("sem low", OFS_SEM_LOW, 32'h0);
    for (int i = 0; i < NUM_MBOX; i++) begin
      rd_chk("mailbox", mb_ofs(i), 32'h0);
    end
    rd_chk("local route", OFS_PCI_ROUTE, 32'h0);
    rd_chk("local enable", OFS_LOC_EN, 32'h0);
    bus_wr(12'h3FC, 32'hFFFF_FFFF, 4'hF);
    irq_chk(7'h00, 8'h00);
    rd_chk("unmapped", 12'h3FC, 32'h0);
  endtask

  // Every route value 0..7 across the mailboxes, local path disabled
  task automatic t_vme();
    logic [7:1] ev;
    int i;
    for (int v = 0; v < 8; v++) begin
      i = v % NUM_MBOX;
      ev = '0;
      if (v != 0) begin
        ev[v] = 1'b1;
      end
      bus_wr(OFS_VME_ROUTE, 32'(v) << (4 * i), 4'hF);
      bus_wr(mb_ofs(i), 32'hC0DE_0000 + 32'(v), 4'hF);
      irq_chk(ev, 8'h00);
      rd_chk("mailbox", mb_ofs(i), 32'hC0DE_0000 + 32'(v));
    end
    // Reserved bits must read back as zero
    wr_rd_chk("vme route", OFS_VME_ROUTE, 32'hFFFF_FFFF, 4'hF, 32'h0000_7777);
    bus_wr(mb_ofs(2), 32'h0, 4'hF);
    irq_chk(7'h40, 8'h00);
    bus_wr(OFS_VME_ROUTE, 32'h0, 4'hF);
  endtask

  task automatic t_local();
    int i;
    bus_wr(OFS_LOC_EN, 32'h0000_000F, 4'h1);
    for (int k = 0; k < 8; k++) begin
      i = k % NUM_MBOX;
      bus_wr(OFS_PCI_ROUTE, 32'(k) << (4 * i), 4'hF);
      bus_wr(mb_ofs(i), 32'h0, (k == 5) ? 4'h0 : 4'hF);
      irq_chk(7'h00, 8'(1) << k);
    end
    bus_wr(OFS_LOC_EN, 32'h0, 4'h1);
    bus_wr(mb_ofs(3), 32'h0, 4'hF);
    irq_chk(7'h00, 8'h00);
    // Partial lanes leave the other bytes alone
    bus_wr(mb_ofs(0), 32'hFFFF_FFFF, 4'hF);
    bus_wr(mb_ofs(0), 32'h1122_3344, 4'h5);
    rd_chk("mailbox lanes", mb_ofs(0), 32'hFF22_FF44);
  endtask

  // Claim, refused steal, release and rewrite for every slot
  task automatic t_sema();
    logic [6:0] tag;
    for (int s = 0; s < NUM_SLOT; s++) begin
      tag = 7'(s + 1);
      sem_claim(s, {1'b1, tag});
      sem_wr(s, 8'hD5);
      sem_chk(s, {1'b1, tag});
      sem_wr(s, 8'h00);
      sem_chk(s, {1'b0, tag});
      sem_wr(s, 8'h2A);
      if (s % 4 == 3) begin
        rd_chk("sem register", (s < 4) ? OFS_SEM_LOW : OFS_SEM_HIGH, 32'h2A2A_2A2A);
      end
    end
  endtask

  // ========================================================================
  // Verdict, main sequence and watchdog
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_reset();
    t_vme();
    t_local();
    t_sema();
    print_verdict();
  end

  // Run needs well under 1000 cycles, so 2000 means a hang
  initial begin
    #200000;
    n_mismatch++;
    print_verdict();
  end

endmodule // msb_top_tb
